// File: rtl/lpm_clkdiv.sv
// Bank of clock dividers producing one-cycle clock enables.
// Assumes a divider value of zero means the clock is shut down.
`timescale 1ns/1ps
module lpm_clkdiv #(parameter int N = 5)
(
	input wire logic pclk,
	input wire logic presetn,
	lpm_div_if.gen d
);

	logic [7:0] cnt_q [N];
	logic [N-1:0] tick_q;

	// ---------------------------------------------------------------
	// Divider counters
	// ---------------------------------------------------------------
	for (genvar i = 0; i < N; i++)
	begin : g_div
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cnt_q[i] <= 8'h00;
				tick_q[i] <= 1'b0;
			end
			else if (!d.run[i] || d.div[i] == 8'h00)
			begin
				cnt_q[i] <= 8'h00;
				tick_q[i] <= 1'b0;
			end
			else if (cnt_q[i] >= d.div[i] - 8'h01)
			begin
				cnt_q[i] <= 8'h00;
				tick_q[i] <= 1'b1;
			end
			else
			begin
				cnt_q[i] <= cnt_q[i] + 8'h01;
				tick_q[i] <= 1'b0;
			end
		end
	end

	assign d.tick = tick_q;

endmodule

// File: rtl/lpm_ctrl.sv
// Low power mode controller: Active, Sleep and Deep-sleep sequencing,
// clock gating, analog power configuration and watchdog clock lock.
// Assumes an APB master on pclk and a processor core on the same clock.
//
// Contract
// (RQ1) A locked watchdog clock source stays powered in every mode.
// (RQ2) Locked internal RC watchdog clock keeps running through Deep-sleep.
// (RQ3) Software selects watchdog oscillator and never locks RC for Power-down.
// (RQ4) Unlocked watchdog in low power needs oscillator kept on by software.
// (RQ5) Any reset gives Active mode with reset power and gating values.
// (RQ6) Active mode powers each analog block individually from run config.
// (RQ7) Main clock selects internal RC by default, system or watchdog osc.
// (RQ8) Peripheral clocks have own dividers; zero divider stops the clock.
// (RQ9) Sleep stops core clock until interrupt or reset.
// (RQ10) Gated-on peripherals keep running in Sleep and can wake core.
// (RQ11) Sleep and Deep-sleep retain state and hold pins static.
// (RQ12) Sleep keeps system clock and peripheral selection as in Active.
// (RQ13) Software enters Sleep with mode field zero, no deep request, wfi.
// (RQ14) Sleep ends on an enabled interrupt or any reset.
// (RQ15) Interrupt wake resumes run config; reset resumes default config.
// (RQ16) Deep-sleep powers down analog except configured detector and osc.
// (RQ17) Deep-sleep gates main and peripheral clocks except watchdog clock.
// (RQ18) Deep-sleep keeps RC running with output off and flash standby.
// (RQ19) Software sets deep mode value then chooses deep-sleep power config.
// (RQ20) Software switches main clock to RC before Deep-sleep.
// (RQ21) Software programs wake config and wake sources before Deep-sleep.
// (RQ22) Software sets deep request then executes wfi last.
// (RQ23) Deep-sleep wakes on enabled pin interrupt among eight pins.
// (RQ24) Mode field and deep request sampled at wfi choose the mode.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module lpm_ctrl #(parameter int NPER = 4)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lpm_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wait_for_interrupt,
	input wire logic deep_sleep_request,
	input wire logic irq_pending,
	input wire logic start_wake,
	input wire logic [7:0] pin_int,
	input wire logic [7:0] pin_int_interrupt_vector_controller_en,
	output logic [lpm_pkg::PDW-1:0] analog_pd,
	output logic irc_out_en,
	output logic flash_standby,
	output logic core_clk_en,
	output logic main_clk_en,
	output logic [1:0] main_clk_sel,
	output logic [lpm_pkg::GW-1:0] ahb_clk_en,
	output logic sys_tick,
	output logic [NPER-1:0] periph_tick,
	output logic wdt_clk_en,
	output logic pin_hold
);

	localparam int NDIV = NPER + 1;

	lpm_pkg::lpm_state_e state_q;
	lpm_pkg::lpm_state_e state_d;
	logic [1:0] pwr_mode_q;
	logic [lpm_pkg::PDW-1:0] run_cfg_q;
	logic [lpm_pkg::PDW-1:0] ds_cfg_q;
	logic [lpm_pkg::PDW-1:0] wake_cfg_q;
	logic [lpm_pkg::GW-1:0] ahb_gate_q;
	logic [7:0] ahb_div_q;
	logic [1:0] mclk_sel_q;
	logic [7:0] per_div_q [NPER];
	logic [7:0] pin_wake_en_q;
	logic wd_sel_q;
	logic wd_lock_q;
	logic [7:0] pin_m_q;
	logic [7:0] pin_s_q;
	logic pin_wake;
	logic deep_wake;
	logic wr_en;
	logic setup;
	logic [31:0] rdata_d;
	logic err_d;
	logic deep;
	logic asleep;

	lpm_div_if #(.N(NDIV)) div_bus ();

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [lpm_pkg::PDW-1:0] lock_force(
		input logic [lpm_pkg::PDW-1:0] pd,
		input logic lock,
		input logic sel);
		logic [lpm_pkg::PDW-1:0] r;
		r = pd;
		if (lock && sel == lpm_pkg::WD_SEL_IRC)
			r[lpm_pkg::PD_IRC] = 1'b0;
		else if (lock)
			r[lpm_pkg::PD_WDOSC] = 1'b0;
		return r;
	endfunction

	function automatic logic hit(input logic [lpm_pkg::AW-1:0] a,
		input logic [lpm_pkg::AW-1:0] ofs);
		return a == ofs;
	endfunction

	// ---------------------------------------------------------------
	// APB access
	// ---------------------------------------------------------------
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && !err_d;
	assign pready = 1'b1;

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if (hit(paddr, lpm_pkg::OFS_PWR_CTRL))
			rdata_d[1:0] = pwr_mode_q;
		else if (hit(paddr, lpm_pkg::OFS_RUN_CFG))
			rdata_d[lpm_pkg::PDW-1:0] = run_cfg_q;
		else if (hit(paddr, lpm_pkg::OFS_DS_CFG))
			rdata_d[lpm_pkg::PDW-1:0] = ds_cfg_q;
		else if (hit(paddr, lpm_pkg::OFS_WAKE_CFG))
			rdata_d[lpm_pkg::PDW-1:0] = wake_cfg_q;
		else if (hit(paddr, lpm_pkg::OFS_AHB_GATE))
			rdata_d[lpm_pkg::GW-1:0] = ahb_gate_q;
		else if (hit(paddr, lpm_pkg::OFS_AHB_DIV))
			rdata_d[7:0] = ahb_div_q;
		else if (hit(paddr, lpm_pkg::OFS_MCLK_SEL))
			rdata_d[1:0] = mclk_sel_q;
		else if (hit(paddr, lpm_pkg::OFS_PER_DIV))
		begin
			for (int i = 0; i < NPER; i++)
				rdata_d[8*i +: 8] = per_div_q[i];
		end
		else if (hit(paddr, lpm_pkg::OFS_PIN_WAKE))
			rdata_d[7:0] = pin_wake_en_q;
		else if (hit(paddr, lpm_pkg::OFS_WDT_CLK))
		begin
			rdata_d[lpm_pkg::WD_SEL] = wd_sel_q;
			rdata_d[lpm_pkg::WD_LOCK] = wd_lock_q;
		end
		else if (hit(paddr, lpm_pkg::OFS_STATUS))
		begin
			rdata_d[3:0] = state_q;
			rdata_d[15:8] = pin_s_q;
		end
		else
			err_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_d;
			pslverr <= err_d;
		end
	end

	// ---------------------------------------------------------------
	// Mode and clock configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_mode_q <= lpm_pkg::PM_SLEEP;
			ds_cfg_q <= lpm_pkg::DS_CFG_RST;
			wake_cfg_q <= lpm_pkg::WAKE_CFG_RST;
			pin_wake_en_q <= 8'h00;
		end
		else if (wr_en)
		begin
			if (hit(paddr, lpm_pkg::OFS_PWR_CTRL))
				pwr_mode_q <= pwdata[1:0];
			if (hit(paddr, lpm_pkg::OFS_DS_CFG))
				ds_cfg_q <= pwdata[lpm_pkg::PDW-1:0];
			if (hit(paddr, lpm_pkg::OFS_WAKE_CFG))
				wake_cfg_q <= pwdata[lpm_pkg::PDW-1:0];
			if (hit(paddr, lpm_pkg::OFS_PIN_WAKE))
				pin_wake_en_q <= pwdata[7:0];
		end
	end

	// Run power config, reloaded from wake config after Deep-sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_cfg_q <= lpm_pkg::RUN_CFG_RST; // RQ5
		else if (state_q == lpm_pkg::ST_WAKE)
			run_cfg_q <= wake_cfg_q;
		else if (wr_en && hit(paddr, lpm_pkg::OFS_RUN_CFG))
			run_cfg_q <= pwdata[lpm_pkg::PDW-1:0]; // RQ6
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ahb_gate_q <= lpm_pkg::AHB_GATE_RST; // RQ5
			ahb_div_q <= lpm_pkg::AHB_DIV_RST;
			mclk_sel_q <= lpm_pkg::MCLK_IRC; // RQ7
		end
		else if (wr_en)
		begin
			if (hit(paddr, lpm_pkg::OFS_AHB_GATE))
				ahb_gate_q <= pwdata[lpm_pkg::GW-1:0];
			if (hit(paddr, lpm_pkg::OFS_AHB_DIV))
				ahb_div_q <= pwdata[7:0];
			if (hit(paddr, lpm_pkg::OFS_MCLK_SEL) &&
				pwdata[1:0] != 2'h3)
				mclk_sel_q <= pwdata[1:0]; // RQ7
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NPER; i++)
				per_div_q[i] <= lpm_pkg::PER_DIV_RST;
		end
		else if (wr_en && hit(paddr, lpm_pkg::OFS_PER_DIV))
		begin
			for (int i = 0; i < NPER; i++)
				per_div_q[i] <= pwdata[8*i +: 8];
		end
	end

	// ---------------------------------------------------------------
	// Watchdog clock source and lock
	// ---------------------------------------------------------------
	// Lock is sticky; only a reset clears it and frees the source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_sel_q <= lpm_pkg::WD_SEL_IRC;
			wd_lock_q <= 1'b0;
		end
		else if (wr_en && hit(paddr, lpm_pkg::OFS_WDT_CLK))
		begin
			if (!wd_lock_q)
				wd_sel_q <= pwdata[lpm_pkg::WD_SEL];
			wd_lock_q <= wd_lock_q | pwdata[lpm_pkg::WD_LOCK];
		end
	end

	// ---------------------------------------------------------------
	// Pin interrupt synchroniser and wake sources
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_m_q <= 8'h00;
			pin_s_q <= 8'h00;
		end
		else
		begin
			pin_m_q <= pin_int;
			pin_s_q <= pin_m_q;
		end
	end

	assign pin_wake = |(pin_s_q & pin_wake_en_q & pin_int_interrupt_vector_controller_en); // RQ23
	assign deep_wake = pin_wake || start_wake;

	// ---------------------------------------------------------------
	// Mode state machine
	// ---------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			lpm_pkg::ST_ACTIVE:
			begin
				if (wait_for_interrupt && !deep_sleep_request)
					state_d = lpm_pkg::ST_SLEEP; // RQ24
				else if (wait_for_interrupt && pwr_mode_q == lpm_pkg::PM_DSLEEP)
					state_d = lpm_pkg::ST_DSLEEP; // RQ24
			end
			lpm_pkg::ST_SLEEP:
			begin
				if (irq_pending)
					state_d = lpm_pkg::ST_ACTIVE; // RQ14
			end
			lpm_pkg::ST_DSLEEP:
			begin
				if (deep_wake)
					state_d = lpm_pkg::ST_WAKE; // RQ23
			end
			lpm_pkg::ST_WAKE:
				state_d = lpm_pkg::ST_ACTIVE;
			default:
				state_d = lpm_pkg::ST_ACTIVE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= lpm_pkg::ST_ACTIVE; // RQ5
		else
			state_q <= state_d;
	end

	assign deep = state_q == lpm_pkg::ST_DSLEEP;
	assign asleep = state_q == lpm_pkg::ST_SLEEP || deep;

	// ---------------------------------------------------------------
	// Power and clock outputs
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			analog_pd <= lpm_pkg::RUN_CFG_RST;
			flash_standby <= 1'b0;
		end
		else if (deep)
		begin
			analog_pd <= lock_force({1'b0, 1'b1,
				ds_cfg_q[lpm_pkg::PD_WDOSC], 1'b1, 1'b1,
				ds_cfg_q[lpm_pkg::PD_BOD], 1'b0},
				wd_lock_q, wd_sel_q); // RQ16 RQ18 RQ1 RQ2
			flash_standby <= 1'b1; // RQ18
		end
		else
		begin
			analog_pd <= lock_force(run_cfg_q, wd_lock_q,
				wd_sel_q); // RQ6 RQ1 RQ15
			flash_standby <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_clk_en <= 1'b1;
			main_clk_en <= 1'b1;
			irc_out_en <= 1'b1;
			ahb_clk_en <= lpm_pkg::AHB_GATE_RST;
			pin_hold <= 1'b0;
		end
		else
		begin
			core_clk_en <= !asleep; // RQ9
			main_clk_en <= !deep; // RQ12 RQ17
			irc_out_en <= !deep || (wd_lock_q &&
				wd_sel_q == lpm_pkg::WD_SEL_IRC); // RQ18 RQ2
			ahb_clk_en <= deep ? '0 : ahb_gate_q; // RQ10 RQ17
			pin_hold <= asleep; // RQ11
		end
	end

	// Watchdog clock survives Deep-sleep only from a powered source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdt_clk_en <= 1'b1;
		else if (!deep)
			wdt_clk_en <= 1'b1;
		else if (wd_lock_q)
			wdt_clk_en <= 1'b1; // RQ1 RQ2
		else
			wdt_clk_en <= wd_sel_q != lpm_pkg::WD_SEL_IRC &&
				!ds_cfg_q[lpm_pkg::PD_WDOSC]; // RQ17 RQ4
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			main_clk_sel <= lpm_pkg::MCLK_IRC;
		else
			main_clk_sel <= mclk_sel_q; // RQ7
	end

	// ---------------------------------------------------------------
	// System and peripheral clock dividers
	// ---------------------------------------------------------------
	assign div_bus.div[0] = ahb_div_q;
	assign div_bus.run[0] = !deep; // RQ12

	for (genvar i = 0; i < NPER; i++)
	begin : g_per
		assign div_bus.div[i+1] = per_div_q[i]; // RQ8
		assign div_bus.run[i+1] = !deep; // RQ17
	end

	lpm_clkdiv #(.N(NDIV)) u_div
	(
		.pclk(pclk),
		.presetn(presetn),
		.d(div_bus.gen)
	);

	assign sys_tick = div_bus.tick[0];
	assign periph_tick = div_bus.tick[NDIV-1:1]; // RQ8

endmodule

// File: rtl/lpm_div_if.sv
// Interface between the mode controller and its clock dividers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lpm_div_if #(parameter int N = 5);
	logic [7:0] div [N];
	logic [N-1:0] run;
	logic [N-1:0] tick;
	modport ctl (output div, output run, input tick);
	modport gen (input div, input run, output tick);
endinterface

// File: rtl/lpm_pkg.sv
// Package of the low power mode controller: register map, field
// positions, reset values and mode states.
// Assumes a 32-bit APB register bus with byte addresses.
package lpm_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam int AW = 8;
	localparam logic [AW-1:0] OFS_PWR_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_RUN_CFG = 8'h04;
	localparam logic [AW-1:0] OFS_DS_CFG = 8'h08;
	localparam logic [AW-1:0] OFS_WAKE_CFG = 8'h0c;
	localparam logic [AW-1:0] OFS_AHB_GATE = 8'h10;
	localparam logic [AW-1:0] OFS_AHB_DIV = 8'h14;
	localparam logic [AW-1:0] OFS_MCLK_SEL = 8'h18;
	localparam logic [AW-1:0] OFS_PER_DIV = 8'h1c;
	localparam logic [AW-1:0] OFS_PIN_WAKE = 8'h20;
	localparam logic [AW-1:0] OFS_WDT_CLK = 8'h24;
	localparam logic [AW-1:0] OFS_STATUS = 8'h28;

	// ---------------------------------------------------------------
	// Analog power-down bits, one means powered down
	// ---------------------------------------------------------------
	localparam int PDW = 7;
	localparam int PD_FLASH = 0;
	localparam int PD_BOD = 1;
	localparam int PD_ADC = 2;
	localparam int PD_SYSOSC = 3;
	localparam int PD_WDOSC = 4;
	localparam int PD_PLL = 5;
	localparam int PD_IRC = 6;
	localparam logic [PDW-1:0] RUN_CFG_RST = 7'h3c;
	localparam logic [PDW-1:0] DS_CFG_RST = 7'h12;
	localparam logic [PDW-1:0] WAKE_CFG_RST = 7'h3c;
	localparam logic [PDW-1:0] PD_ALL = 7'h7f;

	// ---------------------------------------------------------------
	// Clock fields
	// ---------------------------------------------------------------
	localparam int GW = 16;
	localparam logic [GW-1:0] AHB_GATE_RST = 16'h001f;
	localparam logic [7:0] AHB_DIV_RST = 8'h01;
	localparam logic [7:0] PER_DIV_RST = 8'h00;
	localparam logic [1:0] MCLK_IRC = 2'h0;
	localparam logic [1:0] MCLK_SYSOSC = 2'h1;
	localparam logic [1:0] MCLK_WDOSC = 2'h2;
	localparam logic [1:0] PM_SLEEP = 2'h0;
	localparam logic [1:0] PM_DSLEEP = 2'h1;
	localparam int WD_SEL = 0;
	localparam int WD_LOCK = 1;
	localparam logic WD_SEL_IRC = 1'b0;

	// ---------------------------------------------------------------
	// Mode states
	// ---------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_ACTIVE = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_DSLEEP = 4'b0100,
		ST_WAKE = 4'b1000
	} lpm_state_e;

endpackage

// File: tb/lpm_core_model.sv
// Model of the processor core running power management software.
// Assumes the core executes wfi only while its clock is enabled.
`timescale 1ns/1ps
module lpm_core_model
(
	input wire logic pclk,
	input wire logic core_clk_en,
	output logic wait_for_interrupt,
	output logic deep_sleep_request,
	output logic irq_pending
);
	initial
	begin
		wait_for_interrupt = 1'b0;
		deep_sleep_request = 1'b0;
		irq_pending = 1'b0;
	end

	// Request bit first, wait-for-interrupt last
	task automatic sleep(input logic deep);
		@(posedge pclk);
		deep_sleep_request <= deep;
		@(posedge pclk);
		wait_for_interrupt <= core_clk_en;
		@(posedge pclk);
		wait_for_interrupt <= 1'b0;
	endtask

	// Pending interrupt held for n cycles, then cleared
	task automatic irq(input int n);
		@(posedge pclk);
		irq_pending <= 1'b1;
		repeat (n) @(posedge pclk);
		irq_pending <= 1'b0;
	endtask
endmodule

// File: tb/lpm_ctrl_properties.sv
// Checker of the low power mode controller port behaviour.
// Assumes it is bound to lpm_ctrl and sees only its ports.
`timescale 1ns/1ps
module lpm_ctrl_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wait_for_interrupt,
	input wire logic deep_sleep_request,
	input wire logic irq_pending,
	input wire logic start_wake,
	input wire logic [lpm_pkg::PDW-1:0] analog_pd,
	input wire logic flash_standby,
	input wire logic core_clk_en,
	input wire logic main_clk_en,
	input wire logic [1:0] main_clk_sel,
	input wire logic [lpm_pkg::GW-1:0] ahb_clk_en,
	input wire logic pin_hold
);
	// ---------------------------------------------------------------
	// Mode sequences and properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_sleep_out;
		!core_clk_en && pin_hold && main_clk_en;
	endsequence

	AST_SLEEP_ENTRY: assert property (
		wait_for_interrupt && !deep_sleep_request && core_clk_en |-> ##2 s_sleep_out)
		else $error("sleep not entered after wfi");
	AST_SLEEP_HOLD: assert property (
		!irq_pending ##1 s_sleep_out |=> s_sleep_out)
		else $error("sleep left without interrupt");
	AST_SLEEP_WAKE: assert property (
		s_sleep_out ##0 irq_pending |-> ##[1:2] core_clk_en)
		else $error("sleep not left on interrupt");
	AST_SLEEP_CFG: assert property (
		$rose(pin_hold) && main_clk_en |-> $stable(ahb_clk_en)
		&& $stable(analog_pd) && $stable(main_clk_sel))
		else $error("sleep changed the configuration");
	AST_DEEP_GATE: assert property (
		!main_clk_en |-> ahb_clk_en == '0 && !core_clk_en && flash_standby)
		else $error("deep sleep clocks not gated");
	AST_DEEP_ANALOG: assert property (
		flash_standby |-> analog_pd[lpm_pkg::PD_PLL]
		&& analog_pd[lpm_pkg::PD_SYSOSC] && analog_pd[lpm_pkg::PD_ADC]
		&& !analog_pd[lpm_pkg::PD_IRC] && !analog_pd[lpm_pkg::PD_FLASH])
		else $error("deep sleep analog power wrong");
	AST_PIN_HOLD: assert property (
		$changed(pin_hold) |-> core_clk_en == !pin_hold)
		else $error("pin hold out of step with core clock");
	AST_DEEP_WAKE: assert property (
		!main_clk_en && start_wake |-> ##[1:4] main_clk_en)
		else $error("deep sleep not left on wake source");
	AST_RESET_CFG: assert property (
		$rose(presetn) |-> analog_pd == lpm_pkg::RUN_CFG_RST && core_clk_en
		&& ahb_clk_en == lpm_pkg::AHB_GATE_RST
		&& main_clk_sel == lpm_pkg::MCLK_IRC)
		else $error("reset configuration wrong");
endmodule

bind lpm_ctrl lpm_ctrl_properties u_lpm_ctrl_properties (.pclk, .presetn,
	.wait_for_interrupt, .deep_sleep_request, .irq_pending, .start_wake, .analog_pd,
	.flash_standby, .core_clk_en, .main_clk_en, .main_clk_sel, .ahb_clk_en,
	.pin_hold);

// File: tb/tb.sv
// Self-checking bench of the low power mode controller.
// Assumes the core model drives the mode request pins.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic wait_for_interrupt, deep_sleep_request, irq_pending, start_wake;
	logic [7:0] pin_int, pin_int_interrupt_vector_controller_en;
	logic [lpm_pkg::PDW-1:0] analog_pd;
	logic irc_out_en, flash_standby, core_clk_en, main_clk_en, sys_tick;
	logic wdt_clk_en, pin_hold;
	logic [1:0] main_clk_sel;
	logic [lpm_pkg::GW-1:0] ahb_clk_en;
	logic [3:0] periph_tick;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int cnt [0:3];

	lpm_ctrl #(.NPER(4)) u_lpm_ctrl (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_for_interrupt,
		.deep_sleep_request, .irq_pending, .start_wake, .pin_int,
		.pin_int_interrupt_vector_controller_en, .analog_pd, .irc_out_en, .flash_standby,
		.core_clk_en, .main_clk_en, .main_clk_sel, .ahb_clk_en, .sys_tick,
		.periph_tick, .wdt_clk_en, .pin_hold);
	lpm_core_model u_lpm_core_model (.pclk, .core_clk_en, .wait_for_interrupt,
		.deep_sleep_request, .irq_pending);

	// ---------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ---------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic count(input int n);
		cnt = '{0, 0, 0, 0};
		repeat (n)
		begin
			@(posedge pclk);
			cnt[0] += int'(periph_tick[0]);
			cnt[1] += int'(periph_tick[1]);
			cnt[2] += int'(sys_tick);
			cnt[3] += int'(|periph_tick[3:2]);
		end
	endtask

	task automatic wait_wake;
		for (int i = 0; i < 20 && main_clk_en !== 1'b1; i++)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{start_wake, pin_int, pin_int_interrupt_vector_controller_en} = '0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(analog_pd, lpm_pkg::RUN_CFG_RST);
		`CHK(ahb_clk_en, lpm_pkg::AHB_GATE_RST);
		`CHK(main_clk_sel, lpm_pkg::MCLK_IRC);
		apb(1'b0, lpm_pkg::OFS_STATUS, 0);
		`CHK(rdat[3:0], 4'h1);
		apb(1'b0, 8'h2c, 0);
		`CHK(rerr, 1'b1);
		`CHK(rdat, 0);
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, lpm_pkg::OFS_RUN_CFG, 1 << i);
			`CHK(analog_pd, 1 << i);
		end
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, lpm_pkg::OFS_MCLK_SEL, i);
			`CHK(main_clk_sel, (i == 3) ? 2 : i);
		end
		apb(1'b1, lpm_pkg::OFS_RUN_CFG, 0);
		apb(1'b1, lpm_pkg::OFS_PER_DIV, 32'h00000302);
		count(12);
		`CHK(cnt[0], 6);
		`CHK(cnt[1], 4);
		`CHK(cnt[3], 0);
		apb(1'b1, lpm_pkg::OFS_AHB_GATE, 32'h00a5);
		`CHK(ahb_clk_en, 16'h00a5);
		apb(1'b1, lpm_pkg::OFS_PWR_CTRL, lpm_pkg::PM_SLEEP);
		u_lpm_core_model.sleep(1'b0);
		count(12);
		`CHK({core_clk_en, pin_hold, main_clk_en}, 3'b011);
		`CHK(ahb_clk_en, 16'h00a5);
		`CHK(cnt[0], 6);
		`CHK(cnt[2], 12);
		apb(1'b0, lpm_pkg::OFS_STATUS, 0);
		`CHK(rdat[3:0], 4'h2);
		u_lpm_core_model.irq(3);
		repeat (2) @(posedge pclk);
		`CHK({core_clk_en, analog_pd}, 8'h80);
		u_lpm_core_model.sleep(1'b1);
		repeat (3) @(posedge pclk);
		`CHK(core_clk_en, 1'b1);
		apb(1'b1, lpm_pkg::OFS_PWR_CTRL, lpm_pkg::PM_DSLEEP);
		apb(1'b1, lpm_pkg::OFS_DS_CFG, 32'h02);
		apb(1'b1, lpm_pkg::OFS_WDT_CLK, 1);
		apb(1'b1, lpm_pkg::OFS_MCLK_SEL, lpm_pkg::MCLK_IRC);
		apb(1'b1, lpm_pkg::OFS_WAKE_CFG, 32'h38);
		apb(1'b1, lpm_pkg::OFS_PIN_WAKE, 32'h82);
		pin_int_interrupt_vector_controller_en <= 8'h81;
		u_lpm_core_model.sleep(1'b1);
		repeat (3) @(posedge pclk);
		`CHK({main_clk_en, ahb_clk_en, wdt_clk_en}, 18'h1);
		`CHK(analog_pd, 7'h2e);
		`CHK({flash_standby, irc_out_en, pin_hold}, 3'b101);
		count(4);
		`CHK(cnt[0], 0);
		`CHK(cnt[2], 0);
		for (int i = 0; i < 7; i++)
		begin
			pin_int <= 8'(1 << i);
			repeat (5) @(posedge pclk);
			`CHK(main_clk_en, 1'b0);
		end
		apb(1'b0, lpm_pkg::OFS_STATUS, 0);
		`CHK(rdat[15:0], 16'h4004);
		pin_int <= 8'h80;
		wait_wake();
		pin_int <= 8'h00;
		`CHK({main_clk_en, analog_pd}, 8'hb8);
		apb(1'b1, lpm_pkg::OFS_WDT_CLK, 0);
		apb(1'b1, lpm_pkg::OFS_WDT_CLK, 2);
		apb(1'b1, lpm_pkg::OFS_WDT_CLK, 1);
		apb(1'b0, lpm_pkg::OFS_WDT_CLK, 0);
		`CHK(rdat[1:0], 2'h2);
		apb(1'b1, lpm_pkg::OFS_RUN_CFG, 32'h40);
		`CHK(analog_pd, 7'h00);
		apb(1'b1, lpm_pkg::OFS_DS_CFG, 32'h12);
		u_lpm_core_model.sleep(1'b1);
		repeat (3) @(posedge pclk);
		`CHK({analog_pd, irc_out_en, wdt_clk_en}, 9'h0fb);
		start_wake <= 1'b1;
		wait_wake();
		start_wake <= 1'b0;
		`CHK(main_clk_en, 1'b1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, lpm_pkg::OFS_WDT_CLK, 0);
		`CHK({rdat[1:0], analog_pd}, 9'h03c);
		apb(1'b1, lpm_pkg::OFS_WDT_CLK, 1);
		apb(1'b0, lpm_pkg::OFS_WDT_CLK, 0);
		`CHK(rdat[1:0], 2'h1);
		print_verdict();
	end
endmodule
